// ### rtl/counter_slot.sv
module counter_slot (
  input  wire logic                               clk_i,
  input  wire logic                               rst_i,
  input  wire logic                               load_i,
  input  wire logic [fp_simd_pkg::DATA_W-1:0]     load_val_i,
  input  wire logic                               count_i,
  input  wire logic [fp_simd_pkg::INC_W-1:0]      inc_i,
  output logic      [fp_simd_pkg::DATA_W-1:0]     value_o
);
  import fp_simd_pkg::*;

  typedef struct packed {
    logic [DATA_W-1:0] value;
  } slot_state_t;

  slot_state_t st_q;
  slot_state_t st_d;

  always_comb begin
    st_d = st_q;
    // a software load wins over a count in the same cycle
    if (load_i) begin
      st_d.value = load_val_i;
    end else if (count_i) begin
      st_d.value = st_q.value + {{(DATA_W-INC_W){1'b0}}, inc_i};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q <= '{value: RESET_WORD};
    end else begin
      st_q <= st_d;
    end
  end

  assign value_o = st_q.value;
endmodule

// ### rtl/fp_simd_event_counter.sv
// How it works
// - mask bit 15 on scalar single code adds one per scalar single micro-op
// - event code 0EH in bits 31:25 selects scalar double micro-ops
// - scalar double event with mask bit 15 counts all scalar double micro-ops
// - several scalar double micro-ops in one instruction each add one
// - event code 02H selects 64-bit simd integer micro-ops
// - mask bit 15 counts every 64-bit simd micro-op, memory or register operands
// - each 64-bit simd micro-op in an instruction adds its own count
// - event code 1AH selects 128-bit simd integer micro-ops
// - mask bit 15 counts every 128-bit simd micro-op, memory or vector register
// - event code 04H selects legacy float stack micro-ops
// - mask bit 15 counts each legacy float micro-op separately
// - legacy float load, store and register move micro-ops are not counted
// - trace cache misc event advances its counter by two per occurrence
// - trace cache misc event only via the trace cache select pair
//
// Design decisions made here: the address map and the Wishbone register port.
module fp_simd_event_counter (
  input  wire logic                               clk_i,
  input  wire logic                               rst_i,
  input  wire logic                               cyc_i,
  input  wire logic                               stb_i,
  input  wire logic                               we_i,
  input  wire logic [fp_simd_pkg::ADDR_W-1:0]     adr_i,
  input  wire logic [fp_simd_pkg::SEL_W-1:0]      sel_i,
  input  wire logic [fp_simd_pkg::DATA_W-1:0]     dat_i,
  output logic      [fp_simd_pkg::DATA_W-1:0]     dat_o,
  output logic                                    ack_o,
  input  wire logic [fp_simd_pkg::UOP_W-1:0]      scalar_single_cnt_i,
  input  wire logic [fp_simd_pkg::UOP_W-1:0]      scalar_double_cnt_i,
  input  wire logic [fp_simd_pkg::UOP_W-1:0]      simd64_cnt_i,
  input  wire logic [fp_simd_pkg::UOP_W-1:0]      simd128_cnt_i,
  input  wire logic [fp_simd_pkg::UOP_W-1:0]      legacy_float_cnt_i,
  input  wire logic [fp_simd_pkg::UOP_W-1:0]      legacy_float_xfer_cnt_i,
  input  wire logic                               trace_cache_misc_i
);
  import fp_simd_pkg::*;

  typedef struct packed {
    logic [1:0][DATA_W-1:0]       fp_sel;
    logic [1:0][DATA_W-1:0]       tc_sel;
    logic [CNT_N-1:0][DATA_W-1:0] cfg;
    logic [DATA_W-1:0]            dat;
    logic                         ack;
  } regs_t;

  regs_t st_q;
  regs_t st_d;

  logic [CNT_N-1:0][DATA_W-1:0] cnt_val;
  logic [CNT_N-1:0][DATA_W-1:0] cnt_load_val;
  logic [CNT_N-1:0]             cnt_load;
  logic [CNT_N-1:0]             cnt_en;
  logic [CNT_N-1:0][INC_W-1:0]  cnt_inc;
  logic [UOP_W-1:0]             legacy_net;
  logic                         wr_fire;
  logic                         rd_start;

  function automatic logic [ADDR_W-1:0] slot_off(input logic [ADDR_W-1:0] base, input int k);
    slot_off = base + ADDR_W'(k * int'(WORD_BYTES));
  endfunction

  // byte-lane merge so partial writes leave the other lanes untouched
  function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] old,
                                              input logic [DATA_W-1:0] wdat,
                                              input logic [SEL_W-1:0]  lanes,
                                              input logic [DATA_W-1:0] rw_mask);
    logic [DATA_W-1:0] r;
    r = old;
    for (int b = 0; b < SEL_W; b++) begin
      if (lanes[b]) begin
        r[b*8 +: 8] = wdat[b*8 +: 8];
      end
    end
    merge = r & rw_mask;
  endfunction

  function automatic logic [INC_W-1:0] widen(input logic [UOP_W-1:0] n);
    widen = {{(INC_W-UOP_W){1'b0}}, n};
  endfunction

  // per-cycle amount for a float/simd counter, from the micro-op counts of this cycle
  function automatic logic [INC_W-1:0] fp_incr(input logic [DATA_W-1:0] sel,
                                               input logic [UOP_W-1:0]  ss,
                                               input logic [UOP_W-1:0]  sd,
                                               input logic [UOP_W-1:0]  s64,
                                               input logic [UOP_W-1:0]  s128,
                                               input logic [UOP_W-1:0]  lf);
    logic [MASK_W-1:0] m;
    logic [CODE_W-1:0] code;
    m       = sel[MASK_MSB:MASK_LSB];
    code    = sel[EVT_MSB:EVT_LSB];
    fp_incr = '0;
    if (m[MASK_ALL_BIT]) begin
      case (code)
        EVT_SCALAR_SINGLE: fp_incr = widen(ss);
        EVT_SCALAR_DOUBLE: fp_incr = widen(sd);
        EVT_SIMD64:        fp_incr = widen(s64);
        EVT_SIMD128:       fp_incr = widen(s128);
        EVT_LEGACY_FLOAT:  fp_incr = widen(lf);
        default:           fp_incr = '0;
      endcase
    end
  endfunction

  function automatic logic [INC_W-1:0] tc_incr(input logic [DATA_W-1:0] sel, input logic hit);
    logic [MASK_W-1:0] m;
    m       = sel[MASK_MSB:MASK_LSB];
    tc_incr = '0;
    if (hit && m[MASK_FLUSH_BIT] && sel[EVT_MSB:EVT_LSB] == EVT_TRACE_CACHE_MISC_EVENT) begin
      tc_incr = TRACE_CACHE_MISC_EVENT_INC;
    end
  endfunction

  function automatic logic cfg_ok(input logic [DATA_W-1:0] cfg, input logic [CSEL_W-1:0] want);
    cfg_ok = cfg[CFG_EN_BIT] && (cfg[CFG_SEL_MSB:CFG_SEL_LSB] == want);
  endfunction

  // the write lands on the edge where the master sees ack, never earlier
  assign wr_fire  = cyc_i && stb_i && we_i && st_q.ack;
  assign rd_start = cyc_i && stb_i && !st_q.ack;

  // load, store and move micro-ops are a subset; removing them leaves the arithmetic ones
  assign legacy_net = (legacy_float_cnt_i >= legacy_float_xfer_cnt_i) ?
                      (legacy_float_cnt_i - legacy_float_xfer_cnt_i) : '0;

  always_comb begin
    cnt_en       = '0;
    cnt_inc      = '0;
    cnt_load     = '0;
    cnt_load_val = '0;
    for (int k = 0; k < CNT_N; k++) begin
      if (k < TC_SLOTS) begin
        // only the trace cache pair can see the misc event
        cnt_inc[k] = tc_incr(st_q.tc_sel[k / SLOTS_PER_SEL], trace_cache_misc_i);
        cnt_en[k]  = cfg_ok(st_q.cfg[k], CSEL_TC);
      end else begin
        cnt_inc[k] = fp_incr(st_q.fp_sel[(k - TC_SLOTS) / SLOTS_PER_SEL],
                             scalar_single_cnt_i, scalar_double_cnt_i,
                             simd64_cnt_i, simd128_cnt_i, legacy_net);
        cnt_en[k]  = cfg_ok(st_q.cfg[k], CSEL_FP_SIMD);
      end
      cnt_load[k]     = wr_fire && (adr_i == slot_off(OFF_CNT_BASE, k));
      cnt_load_val[k] = merge(cnt_val[k], dat_i, sel_i, {DATA_W{1'b1}});
    end
  end

  always_comb begin
    st_d     = st_q;
    st_d.ack = rd_start;
    if (wr_fire) begin
      case (adr_i)
        OFF_FP_SEL_A: st_d.fp_sel[0] = merge(st_q.fp_sel[0], dat_i, sel_i, SEL_RW_MASK);
        OFF_FP_SEL_B: st_d.fp_sel[1] = merge(st_q.fp_sel[1], dat_i, sel_i, SEL_RW_MASK);
        OFF_TC_SEL_A: st_d.tc_sel[0] = merge(st_q.tc_sel[0], dat_i, sel_i, SEL_RW_MASK);
        OFF_TC_SEL_B: st_d.tc_sel[1] = merge(st_q.tc_sel[1], dat_i, sel_i, SEL_RW_MASK);
        default: begin
          for (int k = 0; k < CNT_N; k++) begin
            if (adr_i == slot_off(OFF_CFG_BASE, k)) begin
              st_d.cfg[k] = merge(st_q.cfg[k], dat_i, sel_i, CFG_RW_MASK);
            end
          end
        end
      endcase
    end
    // writes are acked too but must leave the last read data standing
    if (rd_start && !we_i) begin
      // unmapped offsets read as zero and still get an ack
      st_d.dat = RESET_WORD;
      case (adr_i)
        OFF_FP_SEL_A: st_d.dat = st_q.fp_sel[0];
        OFF_FP_SEL_B: st_d.dat = st_q.fp_sel[1];
        OFF_TC_SEL_A: st_d.dat = st_q.tc_sel[0];
        OFF_TC_SEL_B: st_d.dat = st_q.tc_sel[1];
        default: begin
          for (int k = 0; k < CNT_N; k++) begin
            if (adr_i == slot_off(OFF_CFG_BASE, k)) begin
              st_d.dat = st_q.cfg[k];
            end
            if (adr_i == slot_off(OFF_CNT_BASE, k)) begin
              st_d.dat = cnt_val[k];
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  for (genvar g = 0; g < CNT_N; g++) begin : g_slot
    counter_slot u_slot (
      .clk_i      (clk_i),
      .rst_i      (rst_i),
      .load_i     (cnt_load[g]),
      .load_val_i (cnt_load_val[g]),
      .count_i    (cnt_en[g]),
      .inc_i      (cnt_inc[g]),
      .value_o    (cnt_val[g])
    );
  end

  assign dat_o = st_q.dat;
  assign ack_o = st_q.ack;
endmodule

// ### rtl/fp_simd_pkg.sv
package fp_simd_pkg;

  localparam int DATA_W = 32;
  localparam int ADDR_W = 8;
  localparam int SEL_W  = DATA_W / 8;
  localparam int CNT_N  = 8;
  localparam int UOP_W  = 3;
  localparam int INC_W  = 4;
  localparam int CODE_W = 7;
  localparam int MASK_W = 16;
  localparam int CSEL_W = 3;

  // register byte offsets
  localparam logic [ADDR_W-1:0] OFF_FP_SEL_A = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_FP_SEL_B = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_TC_SEL_A = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_TC_SEL_B = 8'h0C;
  localparam logic [ADDR_W-1:0] OFF_CFG_BASE = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_CNT_BASE = 8'h30;
  localparam logic [ADDR_W-1:0] WORD_BYTES   = 8'h04;

  // event select register fields
  localparam int EVT_MSB  = 31;
  localparam int EVT_LSB  = 25;
  localparam int MASK_MSB = 24;
  localparam int MASK_LSB = 9;
  localparam int MASK_ALL_BIT   = 15;
  localparam int MASK_FLUSH_BIT = 4;

  // counter configuration register fields
  localparam int CFG_EN_BIT  = 12;
  localparam int CFG_SEL_MSB = 15;
  localparam int CFG_SEL_LSB = 13;

  localparam logic [DATA_W-1:0] SEL_RW_MASK = 32'hFFFF_FE00;
  localparam logic [DATA_W-1:0] CFG_RW_MASK = 32'h0000_F000;
  localparam logic [DATA_W-1:0] RESET_WORD  = 32'h0000_0000;

  // event codes
  localparam logic [CODE_W-1:0] EVT_SCALAR_SINGLE = 7'h0A;
  localparam logic [CODE_W-1:0] EVT_SCALAR_DOUBLE = 7'h0E;
  localparam logic [CODE_W-1:0] EVT_SIMD64        = 7'h02;
  localparam logic [CODE_W-1:0] EVT_SIMD128       = 7'h1A;
  localparam logic [CODE_W-1:0] EVT_LEGACY_FLOAT  = 7'h04;
  localparam logic [CODE_W-1:0] EVT_TRACE_CACHE_MISC_EVENT       = 7'h06;

  localparam logic [CSEL_W-1:0] CSEL_FP_SIMD = 3'h1;
  localparam logic [CSEL_W-1:0] CSEL_TC      = 3'h1;

  localparam logic [INC_W-1:0] TRACE_CACHE_MISC_EVENT_INC = 4'h2;

  // counter slots 0..3 are counters 4..7 (trace cache), 4..7 are counters 8..11
  localparam int FIRST_CNT_NUM = 4;
  localparam int TC_SLOTS      = 4;
  localparam int SLOTS_PER_SEL = 2;

endpackage

// ### test/fp_simd_checker_assertions.sv
module fp_simd_checker (
  input  wire logic                           clk_i,
  input  wire logic                           rst_i,
  input  wire logic                           cyc_i,
  input  wire logic                           stb_i,
  input  wire logic                           we_i,
  input  wire logic [fp_simd_pkg::ADDR_W-1:0] adr_i,
  input  wire logic [fp_simd_pkg::DATA_W-1:0] dat_o,
  input  wire logic                           ack_o
);
  timeunit 1ns;
  timeprecision 1ns;
  import fp_simd_pkg::*;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence req_s; cyc_i && stb_i && !ack_o; endsequence
  sequence rd_s; req_s ##0 !we_i; endsequence
  sequence ans_s; ack_o ##1 !ack_o; endsequence
  ack_timing_a: assert property (req_s |=> ans_s) else $error("ack not one cycle after request");
  ack_cause_a: assert property (ack_o |-> $past(cyc_i && stb_i)) else $error("ack without request");
  idle_quiet_a: assert property (!(cyc_i && stb_i) && !ack_o |=> !ack_o) else $error("ack while idle");
  // read data only moves when a read is answered
  read_hold_a: assert property ($changed(dat_o) && !$past(rst_i) |-> ack_o && !$past(we_i))
    else $error("read data moved outside a read");
  unmapped_zero_a: assert property (rd_s ##0 adr_i >= 8'h50 |=> dat_o == 32'h0000_0000)
    else $error("unmapped read not zero");
  misalign_zero_a: assert property (rd_s ##0 adr_i[1:0] != 2'b00 |=> dat_o == 32'h0000_0000)
    else $error("misaligned read not zero");
  select_low_a: assert property (rd_s ##0 adr_i < 8'h10 |=> dat_o[8:0] == 9'h000)
    else $error("select low bits not zero");
  config_bits_a: assert property (rd_s ##0 adr_i inside {[8'h10:8'h2F]} |=> (dat_o & ~CFG_RW_MASK) == '0)
    else $error("config reserved bits set");
endmodule
bind fp_simd_event_counter fp_simd_checker u_chk (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
  .we_i(we_i), .adr_i(adr_i), .dat_o(dat_o), .ack_o(ack_o));

// ### test/test_fp_simd_event_counter.sv
module test_fp_simd_event_counter;
  timeunit 1ns;
  timeprecision 1ns;
  import fp_simd_pkg::*;
  logic              clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, misc;
  logic [ADDR_W-1:0] adr_i;
  logic [DATA_W-1:0] dat_i, dat_o, rd;
  logic [UOP_W-1:0]  u [6];
  int                errors, n_tests;
  localparam logic [DATA_W-1:0] ALL = 32'h0100_0000, FLUSH = 32'h0000_2000, CFG_ON = 32'h0000_3000;
  localparam logic [17:0] V = {3'd1, 3'd2, 3'd3, 3'd4, 3'd6, 3'd1};
  fp_simd_event_counter u_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(4'hF), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .scalar_single_cnt_i(u[0]),
    .scalar_double_cnt_i(u[1]), .simd64_cnt_i(u[2]), .simd128_cnt_i(u[3]), .legacy_float_cnt_i(u[4]),
    .legacy_float_xfer_cnt_i(u[5]), .trace_cache_misc_i(misc));
  uop_source u_src (.clk_i(clk_i), .ss_o(u[0]), .sd_o(u[1]), .s64_o(u[2]), .s128_o(u[3]), .lf_o(u[4]),
    .xf_o(u[5]), .misc_o(misc));
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  task automatic report_and_stop;
    $display("tests %0d errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  // the master never counts on a latency: it waits for ack, bounded
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc_i <= 1'b1; stb_i <= 1'b1; we_i <= w; adr_i <= a; dat_i <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 20);
    rd = dat_o;
    if (n >= 20) chk("ack_o", 32'h1, 32'h0);
    cyc_i <= 1'b0; stb_i <= 1'b0; we_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, '0);
    chk($sformatf("reg_%h", a), e, rd);
  endtask
  task automatic t_reset;
    rdchk(OFF_FP_SEL_A, RESET_WORD);
    rdchk(8'h40, RESET_WORD);
    rdchk(8'h80, 32'h0000_0000);
    rdchk(8'h41, 32'h0000_0000);
    wb(1'b1, OFF_FP_SEL_A, 32'hFFFF_FFFF);
    rdchk(OFF_FP_SEL_A, SEL_RW_MASK);
    $display("test reset done");
  endtask
  task automatic t_codes;
    logic [CODE_W-1:0] c [5] = '{EVT_SCALAR_SINGLE, EVT_SCALAR_DOUBLE, EVT_SIMD64, EVT_SIMD128, EVT_LEGACY_FLOAT};
    int e [5] = '{1, 2, 3, 4, 5};
    wb(1'b1, 8'h20, CFG_ON);
    for (int i = 0; i < 5; i++) begin
      for (int m = 0; m < 2; m++) begin
        wb(1'b1, OFF_FP_SEL_A, {c[i], 25'h0} | (m == 0 ? ALL : '0));
        wb(1'b1, 8'h40, '0);
        u_src.fire(V, 1'b0, 2);
        rdchk(8'h40, m == 0 ? 32'(2 * e[i]) : '0);
      end
    end
    $display("test codes done");
  endtask
  task automatic t_route;
    wb(1'b1, OFF_FP_SEL_A, {EVT_SIMD128, 25'h0} | ALL);
    wb(1'b1, OFF_FP_SEL_B, {EVT_SCALAR_DOUBLE, 25'h0} | ALL);
    for (int k = 4; k < 8; k++) begin
      wb(1'b1, 8'(8'h10 + 4 * k), CFG_ON);
      wb(1'b1, 8'(8'h30 + 4 * k), '0);
    end
    u_src.fire(V, 1'b0, 1);
    for (int k = 4; k < 8; k++) rdchk(8'(8'h30 + 4 * k), k < 6 ? 32'h4 : 32'h2);
    $display("test route done");
  endtask
  task automatic t_cfg;
    logic [31:0] v [2] = '{32'h0000_2000, 32'hFFFF_5FFF};
    for (int i = 0; i < 2; i++) begin
      wb(1'b1, 8'h20, v[i]);
      rdchk(8'h20, v[i] & CFG_RW_MASK);
      wb(1'b1, 8'h40, '0);
      u_src.fire(V, 1'b0, 1);
      rdchk(8'h40, '0);
    end
    $display("test config done");
  endtask
  task automatic t_tc;
    wb(1'b1, OFF_TC_SEL_A, {EVT_TRACE_CACHE_MISC_EVENT, 25'h0} | FLUSH);
    wb(1'b1, OFF_FP_SEL_A, {EVT_TRACE_CACHE_MISC_EVENT, 25'h0} | FLUSH);
    wb(1'b1, 8'h10, CFG_ON);
    wb(1'b1, 8'h20, CFG_ON);
    wb(1'b1, 8'h30, '0);
    wb(1'b1, 8'h40, '0);
    u_src.fire('0, 1'b1, 3);
    rdchk(8'h30, 32'(3 * TRACE_CACHE_MISC_EVENT_INC));
    rdchk(8'h40, '0);
    $display("test trace cache done");
  endtask
  initial begin
    #200000;
    errors++;
    report_and_stop;
  end
  initial begin
    rst_i = 1'b1; cyc_i = 1'b0; stb_i = 1'b0; we_i = 1'b0; adr_i = '0; dat_i = '0;
    errors = 0; n_tests = 0;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset;
    t_codes;
    t_route;
    t_cfg;
    t_tc;
    report_and_stop;
  end
endmodule

// ### test/uop_source.sv
module uop_source (
  input  wire logic                          clk_i,
  output logic      [fp_simd_pkg::UOP_W-1:0] ss_o,
  output logic      [fp_simd_pkg::UOP_W-1:0] sd_o,
  output logic      [fp_simd_pkg::UOP_W-1:0] s64_o,
  output logic      [fp_simd_pkg::UOP_W-1:0] s128_o,
  output logic      [fp_simd_pkg::UOP_W-1:0] lf_o,
  output logic      [fp_simd_pkg::UOP_W-1:0] xf_o,
  output logic                               misc_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial {ss_o, sd_o, s64_o, s128_o, lf_o, xf_o, misc_o} = '0;
  // xf is a subset of lf, as the pipeline reports it
  task automatic fire(input logic [17:0] v, input logic m, input int n);
    repeat (n) begin
      @(posedge clk_i);
      {ss_o, sd_o, s64_o, s128_o, lf_o, xf_o} <= v;
      misc_o <= m;
    end
    @(posedge clk_i);
    {ss_o, sd_o, s64_o, s128_o, lf_o, xf_o, misc_o} <= '0;
  endtask
endmodule
